// ---- logic/lqta_pkg.sv ----
// Purpose: Shared constants for the link quality threshold access block
// Assumes: AXI4-Lite with 32-bit data, one register word at index 0x1e
// Notes:   Register index times four gives the byte address

package lqta_pkg;

  // Register map
  localparam logic [7:0]  DATA_ACCESS_INDEX = 8'h1e;             // Printed register index
  localparam int          ADDR_W            = 8;                 // Byte address width
  localparam logic [7:0]  DATA_ACCESS_ADDR  = 8'(DATA_ACCESS_INDEX * 4); // Byte address 0x78

  // Field positions inside the data access register
  localparam int          RSVD_HI_BIT       = 15;                // Reserved field top
  localparam int          RSVD_LO_BIT       = 14;                // Reserved field bottom
  localparam int          SAMPLE_BIT        = 13;                // Sample request
  localparam int          TRIGGER_BIT       = 12;                // Threshold write trigger
  localparam int          PSEL_HI_BIT       = 11;                // Parameter select top
  localparam int          PSEL_LO_BIT       = 9;                 // Parameter select bottom
  localparam int          TSEL_BIT          = 8;                 // Low/high threshold select
  localparam int          DATA_HI_BIT       = 7;                 // Data byte top
  localparam int          DATA_LO_BIT       = 0;                 // Data byte bottom

  // Parameter select encodings
  localparam logic [2:0]  PSEL_EQ_C1        = 3'h0;              // Equaliser coefficient one
  localparam logic [2:0]  PSEL_GAIN         = 3'h1;              // Digital gain control
  localparam logic [2:0]  PSEL_BLW          = 3'h2;              // Baseline wander
  localparam logic [2:0]  PSEL_FREQ_OFS     = 3'h3;              // Frequency offset
  localparam logic [2:0]  PSEL_FREQ_CTL     = 3'h4;              // Frequency control
  localparam int          NUM_PARAMS        = 5;                 // Parameters served
  localparam int          BYTE_W            = 8;                 // Threshold and sample width
  localparam int          THR_IDX_W         = 4;                 // {parameter, low/high}

  // Reset values
  localparam logic [2:0]  PSEL_RESET        = 3'h0;              // Parameter select
  localparam logic [7:0]  BYTE_RESET        = 8'h00;             // Thresholds and sample

  // AXI responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;              // Mapped access
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;              // Unmapped access

endpackage : lqta_pkg

// ---- logic/lqta_thr_if.sv ----
// Purpose: Carries threshold store accesses between the control logic and memory
// Assumes: One write port and one read port on the same clock
// Notes:   Read data is registered inside the memory

`timescale 1ns/1ps

interface lqta_thr_if #(
  parameter int IDX_W  = lqta_pkg::THR_IDX_W,
  parameter int DATA_W = lqta_pkg::BYTE_W
);
  logic              wr_en;    // One-cycle write strobe
  logic [IDX_W-1:0]  wr_idx;   // Threshold written
  logic [DATA_W-1:0] wr_data;  // Byte written
  logic [IDX_W-1:0]  rd_idx;   // Threshold looked at
  logic [DATA_W-1:0] rd_data;  // Registered read byte

  modport ctl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : lqta_thr_if

// ---- logic/lqta_thr_mem.sv ----
// Purpose: Threshold storage, one byte per parameter and low/high side
// Assumes: Indices at or above DEPTH are never stored
// Notes:   Read data comes out of a register one cycle after the index

`timescale 1ns/1ps

module lqta_thr_mem #(
  parameter int DEPTH = 2 * lqta_pkg::NUM_PARAMS  // Low and high per parameter
) (
  input  wire logic   clk_in,
  input  wire logic   arst_n_in,
  lqta_thr_if.mem     port
);

  // Index width must reach every entry
  if (DEPTH > (1 << lqta_pkg::THR_IDX_W)) begin : g_depth_check
    $error("lqta_thr_mem: DEPTH exceeds index range");
  end

  logic [lqta_pkg::BYTE_W-1:0] store_r [DEPTH];  // Threshold bytes
  logic [lqta_pkg::BYTE_W-1:0] rd_data_r;        // Registered read
  logic [lqta_pkg::BYTE_W-1:0] rd_data_nxt;      // Next read value

  // One entry per threshold; only the addressed one takes a write
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        store_r[i] <= lqta_pkg::BYTE_RESET;
      end else if (port.wr_en && (port.wr_idx == i)) begin
        store_r[i] <= port.wr_data;
      end
    end
  end

  // Out-of-range index reads as zero rather than aliasing an entry
  always_comb begin
    rd_data_nxt = lqta_pkg::BYTE_RESET;
    if (int'(port.rd_idx) < DEPTH) begin
      rd_data_nxt = store_r[port.rd_idx];
    end
  end

  // Read register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_r <= lqta_pkg::BYTE_RESET;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign port.rd_data = rd_data_r;

endmodule // lqta_thr_mem

// ---- logic/lqta_top.sv ----
// Purpose: Indirect access register for link quality thresholds and samples
// Assumes: AXI4-Lite slave, 32-bit data, one write and one read in flight at most
// Notes:   Parameter values arrive from same-clock DSP logic, so no synchroniser
//
// Overview of operation
// - Bits 15:14 ignore writes, read zero
// - Sample bit set captures selected parameter value
// - Trigger writes data byte to selected threshold
// - Trigger bit always reads back zero
// - Select code picks one of five parameters
// - Threshold select zero low, one high
// - Sample clear: written byte is threshold data
// - Sample clear: read returns selected threshold
// - Sample set: read returns sampled value
// - Sampled value held until next sampling write
//
// The AXI4-Lite slave port was left to the implementer.

`timescale 1ns/1ps

module lqta_top #(
  parameter int NUM_PARAMS = lqta_pkg::NUM_PARAMS  // Parameters with thresholds
) (
  input  wire logic                                  CLOCK_IN,
  input  wire logic                                  ARST_N_IN,
  // Current DSP parameter values, parameter k in byte k
  input  wire logic [NUM_PARAMS*lqta_pkg::BYTE_W-1:0] PARAM_VALUE_IN,
  // AXI4-Lite write address
  input  wire logic                                  S_AXI_AWVALID_IN,
  output logic                                       S_AXI_AWREADY_OUT,
  input  wire logic [lqta_pkg::ADDR_W-1:0]            S_AXI_AWADDR_IN,
  // AXI4-Lite write data
  input  wire logic                                  S_AXI_WVALID_IN,
  output logic                                       S_AXI_WREADY_OUT,
  input  wire logic [31:0]                           S_AXI_WDATA_IN,
  input  wire logic [3:0]                            S_AXI_WSTRB_IN,
  // AXI4-Lite write response
  output logic                                       S_AXI_BVALID_OUT,
  input  wire logic                                  S_AXI_BREADY_IN,
  output logic [1:0]                                 S_AXI_BRESP_OUT,
  // AXI4-Lite read address
  input  wire logic                                  S_AXI_ARVALID_IN,
  output logic                                       S_AXI_ARREADY_OUT,
  input  wire logic [lqta_pkg::ADDR_W-1:0]            S_AXI_ARADDR_IN,
  // AXI4-Lite read data
  output logic                                       S_AXI_RVALID_OUT,
  input  wire logic                                  S_AXI_RREADY_IN,
  output logic [31:0]                                S_AXI_RDATA_OUT,
  output logic [1:0]                                 S_AXI_RRESP_OUT
);

  // The select field has three bits and the decode assumes five codes
  if (NUM_PARAMS != lqta_pkg::NUM_PARAMS) begin : g_param_check
    $error("lqta_top: NUM_PARAMS must match the five-code select field");
  end

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} lqta_rd_state_type;

  // Control fields of the access register
  logic                          sample_en_r, sample_en_nxt;   // Sample request bit
  logic [2:0]                    psel_r, psel_nxt;             // Parameter select
  logic                          tsel_r, tsel_nxt;             // Low/high select
  logic [lqta_pkg::BYTE_W-1:0]   sample_r, sample_nxt;         // Held sampled value

  // Write channel state
  logic                          aw_have_r, aw_have_nxt;       // Address captured
  logic [lqta_pkg::ADDR_W-1:0]   awaddr_r, awaddr_nxt;         // Captured address
  logic                          w_have_r, w_have_nxt;         // Data captured
  logic [31:0]                   wdata_r, wdata_nxt;           // Captured data
  logic [3:0]                    wstrb_r, wstrb_nxt;           // Captured strobes
  logic                          awready_r, awready_nxt;       // Address ready
  logic                          wready_r, wready_nxt;         // Data ready
  logic                          bvalid_r, bvalid_nxt;         // Response valid
  logic [1:0]                    bresp_r, bresp_nxt;           // Response code
  logic                          commit;                       // Write takes effect
  logic                          wr_hit;                       // Write hits the register

  // Read channel state
  lqta_rd_state_type             rd_state_r, rd_state_nxt;     // Read sequencer
  logic                          ar_hit_r, ar_hit_nxt;         // Read hits the register
  logic                          arready_r, arready_nxt;       // Address ready
  logic                          rvalid_r, rvalid_nxt;         // Read data valid
  logic [31:0]                   rdata_r, rdata_nxt;           // Read data
  logic [1:0]                    rresp_r, rresp_nxt;           // Read response

  lqta_thr_if thr ();                                          // Threshold store port

  // Threshold storage
  lqta_thr_mem #(
    .DEPTH     (2 * NUM_PARAMS)
  ) u_thr_mem (
    .clk_in    (CLOCK_IN),
    .arst_n_in (ARST_N_IN),
    .port      (thr.mem)
  );

  // Read port follows the current selection, so reads see it a cycle later
  assign thr.rd_idx = {psel_r, tsel_r};

  // Write channel: accept address and data in either order, answer after both
  always_comb begin
    aw_have_nxt = aw_have_r;
    awaddr_nxt  = awaddr_r;
    w_have_nxt  = w_have_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    // Capture address when offered and free
    if (S_AXI_AWVALID_IN && awready_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt  = S_AXI_AWADDR_IN;
    end
    // Capture data when offered and free
    if (S_AXI_WVALID_IN && wready_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = S_AXI_WDATA_IN;
      wstrb_nxt  = S_AXI_WSTRB_IN;
    end
    // Response drained by master
    if (bvalid_r && S_AXI_BREADY_IN) begin
      bvalid_nxt = 1'b0;
    end
    // Both halves held: apply and respond
    if (commit) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? lqta_pkg::RESP_OKAY : lqta_pkg::RESP_SLVERR;
    end
    // Ready only while nothing is held, so each beat is taken once
    awready_nxt = !aw_have_nxt;
    wready_nxt  = !w_have_nxt;
  end

  // Commit waits for a drained response so two writes never share one answer
  assign commit = aw_have_r && w_have_r && !bvalid_r;
  assign wr_hit = (awaddr_r[lqta_pkg::ADDR_W-1:2] == lqta_pkg::DATA_ACCESS_ADDR[7:2]);

  // Write channel registers
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      aw_have_r <= 1'b0;
      awaddr_r  <= '0;
      w_have_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= lqta_pkg::RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      awaddr_r  <= awaddr_nxt;
      w_have_r  <= w_have_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // Register effects of a committed write
  always_comb begin
    sample_en_nxt = sample_en_r;
    psel_nxt      = psel_r;
    tsel_nxt      = tsel_r;
    sample_nxt    = sample_r;
    thr.wr_en     = 1'b0;
    thr.wr_idx    = {wdata_r[lqta_pkg::PSEL_HI_BIT:lqta_pkg::PSEL_LO_BIT],
                     wdata_r[lqta_pkg::TSEL_BIT]};
    thr.wr_data   = wdata_r[lqta_pkg::DATA_HI_BIT:lqta_pkg::DATA_LO_BIT];
    // Upper lane holds the control fields; bits 15:14 are dropped
    if (commit && wr_hit && wstrb_r[1]) begin
      sample_en_nxt = wdata_r[lqta_pkg::SAMPLE_BIT];
      psel_nxt      = wdata_r[lqta_pkg::PSEL_HI_BIT:lqta_pkg::PSEL_LO_BIT];
      tsel_nxt      = wdata_r[lqta_pkg::TSEL_BIT];
      // New sampling sequence: capture the chosen parameter now
      if (wdata_r[lqta_pkg::SAMPLE_BIT]) begin
        sample_nxt = lqta_pkg::BYTE_RESET;
        // Codes past the fifth parameter sample as zero
        if (int'(psel_nxt) < NUM_PARAMS) begin
          sample_nxt = PARAM_VALUE_IN[int'(psel_nxt)*lqta_pkg::BYTE_W +: lqta_pkg::BYTE_W];
        end
      end
      // Trigger needs the data lane too, else the byte would be stale
      if (wdata_r[lqta_pkg::TRIGGER_BIT] && wstrb_r[0]
          && (int'(psel_nxt) < NUM_PARAMS)) begin
        thr.wr_en = 1'b1;
      end
    end
  end

  // Control registers; the trigger bit is never stored
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sample_en_r <= 1'b0;
      psel_r      <= lqta_pkg::PSEL_RESET;
      tsel_r      <= 1'b0;
      sample_r    <= lqta_pkg::BYTE_RESET;
    end else begin
      sample_en_r <= sample_en_nxt;
      psel_r      <= psel_nxt;
      tsel_r      <= tsel_nxt;
      sample_r    <= sample_nxt;
    end
  end

  // Read sequencer: one wait cycle lets the registered store output settle
  always_comb begin
    rd_state_nxt = rd_state_r;
    ar_hit_nxt   = ar_hit_r;
    arready_nxt  = arready_r;
    rvalid_nxt   = rvalid_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    unique case (rd_state_r)
      // Waiting for an address
      RD_IDLE: begin
        arready_nxt = 1'b1;
        if (S_AXI_ARVALID_IN && arready_r) begin
          ar_hit_nxt   = (S_AXI_ARADDR_IN[lqta_pkg::ADDR_W-1:2]
                          == lqta_pkg::DATA_ACCESS_ADDR[7:2]);
          arready_nxt  = 1'b0;
          rd_state_nxt = RD_WAIT;
        end
      end
      // Compose the word from current state
      RD_WAIT: begin
        rdata_nxt  = 32'h0000_0000;
        rresp_nxt  = lqta_pkg::RESP_SLVERR;
        if (ar_hit_r) begin
          rresp_nxt = lqta_pkg::RESP_OKAY;
          rdata_nxt[lqta_pkg::SAMPLE_BIT] = sample_en_r;
          rdata_nxt[lqta_pkg::PSEL_HI_BIT:lqta_pkg::PSEL_LO_BIT] = psel_r;
          rdata_nxt[lqta_pkg::TSEL_BIT] = tsel_r;
          // Sampled value replaces the threshold while sampling is on
          rdata_nxt[lqta_pkg::DATA_HI_BIT:lqta_pkg::DATA_LO_BIT] =
            sample_en_r ? sample_r : thr.rd_data;
        end
        rvalid_nxt   = 1'b1;
        rd_state_nxt = RD_RESP;
      end
      // Hold data until the master takes it
      RD_RESP: begin
        if (S_AXI_RREADY_IN) begin
          rvalid_nxt   = 1'b0;
          arready_nxt  = 1'b1;
          rd_state_nxt = RD_IDLE;
        end
      end
      default: begin
        rd_state_nxt = RD_IDLE;
      end
    endcase
  end

  // Read channel registers
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rd_state_r <= RD_IDLE;
      ar_hit_r   <= 1'b0;
      arready_r  <= 1'b0;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= lqta_pkg::RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      ar_hit_r   <= ar_hit_nxt;
      arready_r  <= arready_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign S_AXI_AWREADY_OUT = awready_r;
  assign S_AXI_WREADY_OUT  = wready_r;
  assign S_AXI_BVALID_OUT  = bvalid_r;
  assign S_AXI_BRESP_OUT   = bresp_r;
  assign S_AXI_ARREADY_OUT = arready_r;
  assign S_AXI_RVALID_OUT  = rvalid_r;
  assign S_AXI_RDATA_OUT   = rdata_r;
  assign S_AXI_RRESP_OUT   = rresp_r;

endmodule // lqta_top

// ---- tb/lqta_props.sv ----
// Purpose: Port-level checks on the link quality threshold access block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Read and write latencies follow the hand-over contract

`timescale 1ns/1ps

module lqta_props (
  input wire logic                          CLOCK_IN,
  input wire logic                          ARST_N_IN,
  input wire logic                          S_AXI_AWVALID_IN,
  input wire logic                          S_AXI_AWREADY_OUT,
  input wire logic [lqta_pkg::ADDR_W-1:0]   S_AXI_AWADDR_IN,
  input wire logic                          S_AXI_WVALID_IN,
  input wire logic                          S_AXI_WREADY_OUT,
  input wire logic                          S_AXI_BVALID_OUT,
  input wire logic                          S_AXI_BREADY_IN,
  input wire logic [1:0]                    S_AXI_BRESP_OUT,
  input wire logic                          S_AXI_ARVALID_IN,
  input wire logic                          S_AXI_ARREADY_OUT,
  input wire logic [lqta_pkg::ADDR_W-1:0]   S_AXI_ARADDR_IN,
  input wire logic                          S_AXI_RVALID_OUT,
  input wire logic                          S_AXI_RREADY_IN,
  input wire logic [31:0]                   S_AXI_RDATA_OUT,
  input wire logic [1:0]                    S_AXI_RRESP_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);

  // Handshakes and address decode; only bits 7:2 select the word
  logic ar_hs;   // Read address taken
  logic wr_hs;   // Address and data taken together
  logic ar_map;  // Read hits the register word
  logic aw_map;  // Write hits the register word
  assign ar_hs  = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign wr_hs  = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  assign ar_map = S_AXI_ARADDR_IN[7:2] == lqta_pkg::DATA_ACCESS_ADDR[7:2];
  assign aw_map = S_AXI_AWADDR_IN[7:2] == lqta_pkg::DATA_ACCESS_ADDR[7:2];

  // Reserved and upper bits never read back as ones
  property p_rd_rsvd_zero;
    S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:14] == 18'h00000;
  endproperty
  a_rd_rsvd_zero: assert property (p_rd_rsvd_zero)
    else $error("reserved bits read nonzero");
  // Trigger position is self clearing on every read
  property p_rd_trig_zero;
    S_AXI_RVALID_OUT |-> !S_AXI_RDATA_OUT[12];
  endproperty
  a_rd_trig_zero: assert property (p_rd_trig_zero)
    else $error("trigger bit read as one");
  // Read answer is seen at the second edge after the address is taken
  property p_rd_latency;
    ar_hs |=> !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT ##1 S_AXI_RVALID_OUT;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("read answer late or early");
  // Unmapped read answers an error with zero data, checked on the first cycle it stands
  property p_rd_unmapped;
    ar_hs && !ar_map |-> ##2 S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == lqta_pkg::RESP_SLVERR
      && S_AXI_RDATA_OUT == '0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not refused");
  // Mapped read answers okay
  property p_rd_mapped_ok;
    ar_hs && ar_map |-> ##2 S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == lqta_pkg::RESP_OKAY;
  endproperty
  a_rd_mapped_ok: assert property (p_rd_mapped_ok)
    else $error("mapped read not okay");
  // Read data stands until taken, so a sampled value cannot slip away
  property p_rvalid_hold;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped early");
  // Write response stands until taken
  property p_bvalid_hold;
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped");
  // Response two edges after both beats, coded by the decode of the address then taken
  property p_wr_answer;
    wr_hs && !S_AXI_BVALID_OUT |-> ##2 S_AXI_BVALID_OUT &&
      S_AXI_BRESP_OUT == ($past(aw_map, 2) ? lqta_pkg::RESP_OKAY : lqta_pkg::RESP_SLVERR);
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response wrong");
  // One write at a time: address channel closes after its beat
  property p_aw_drop;
    wr_hs |=> !S_AXI_AWREADY_OUT;
  endproperty
  a_aw_drop: assert property (p_aw_drop)
    else $error("address ready stayed high");
endmodule // lqta_props

bind lqta_top lqta_props u_props (.CLOCK_IN, .ARST_N_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
  .S_AXI_AWADDR_IN, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN,
  .S_AXI_BRESP_OUT, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_ARADDR_IN, .S_AXI_RVALID_OUT,
  .S_AXI_RREADY_IN, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT);

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the link quality threshold access block
// Assumes: Bench acts as the AXI4-Lite master; parameter bytes are driven directly
// Notes:   Expected values come from a small threshold table kept here

`timescale 1ns/1ps

module tb;
  localparam int         PW    = lqta_pkg::NUM_PARAMS * lqta_pkg::BYTE_W; // Parameter bus
  localparam logic [PW-1:0] PV = 40'h5a4b3c2d1e;            // First parameter set
  localparam logic [7:0] REG_A = lqta_pkg::DATA_ACCESS_ADDR; // Mapped word
  localparam logic [7:0] BAD_A = 8'h7c;                     // Unmapped neighbour
  localparam logic [1:0] OK    = lqta_pkg::RESP_OKAY;
  localparam logic [1:0] ERR   = lqta_pkg::RESP_SLVERR;
  logic          clk, arst_n;                    // Clock and reset
  logic [PW-1:0] param_val;                      // Live parameter bytes
  logic          awv, awr, wv, wr, bv, br;       // Write channels
  logic          arv, arr, rv, rr;               // Read channels
  logic [7:0]    awa, ara;                       // Addresses
  logic [31:0]   wd, rd;                         // Data
  logic [3:0]    ws;                             // Byte strobes
  logic [1:0]    bresp, rresp;                   // Responses
  logic [7:0]    thr [10];                       // Expected thresholds
  logic [31:0]   v;                              // Last read word
  int            fails, checks_done;
  int            lag;                            // Edges before bready or rready rises

  lqta_top uut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .PARAM_VALUE_IN(param_val),
    .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp));

  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test;
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Case-equality compare so unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register word layout: sample, trigger, select, low/high, byte
  function automatic logic [31:0] fld(input logic s, input logic t, input logic [2:0] p,
                                      input logic h, input logic [7:0] b);
    return {16'h0000, 2'b00, s, t, p, h, b};
  endfunction

  // Write: both beats offered together, each released when taken; bready may lag
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; ws <= 4'h3; br <= (lag == 0);
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (n + 1 == lag) br <= 1'b1;
      if (bv && br) begin
        done = 1'b1;
        br <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end
    if (!done) begin
      fails++;
      $display("[FAIL] %0t ns: write answer timed out", $time);
      finish_test();
    end
  endtask

  // Read: ready raised after the lag, then held up until the answer is sampled
  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    arv <= 1'b1; ara <= a; rr <= (lag == 0);
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (n + 1 == lag) rr <= 1'b1;
      if (rv && rr) begin
        done = 1'b1;
        v = rd;
        rr <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
    if (!done) begin
      fails++;
      $display("[FAIL] %0t ns: read answer timed out", $time);
      finish_test();
    end
  endtask

  // Every threshold written with reserved bits set, then kept against plain writes
  task automatic t_thr_table;
    for (int i = 0; i < 10; i++) begin
      thr[i] = 8'(8'ha1 + i * 8'h13);
      wr_reg(REG_A, 32'hc000 | fld(0, 1, 3'(i / 2), i[0], thr[i]), OK);
      rd_reg(REG_A, OK);
      chk(v, fld(0, 0, 3'(i / 2), i[0], thr[i]));
    end
    for (int i = 0; i < 10; i++) begin
      wr_reg(REG_A, fld(0, 0, 3'(i / 2), i[0], ~thr[i]), OK);
      rd_reg(REG_A, OK);
      chk(v, fld(0, 0, 3'(i / 2), i[0], thr[i]));
    end
  endtask

  // Sampling of each parameter, hold against a changing source, resample
  task automatic t_sample;
    for (int p = 0; p < 5; p++) begin
      wr_reg(REG_A, fld(1, 0, 3'(p), 0, 8'h00), OK);
      rd_reg(REG_A, OK);
      chk(v, fld(1, 0, 3'(p), 0, PV[p*8 +: 8]));
    end
    param_val <= ~PV;
    rd_reg(REG_A, OK);
    chk(v, fld(1, 0, 3'h4, 0, PV[39:32]));
    wr_reg(REG_A, fld(1, 0, 3'h4, 0, 8'h00), OK);
    rd_reg(REG_A, OK);
    chk(v, fld(1, 0, 3'h4, 0, ~PV[39:32]));
    wr_reg(REG_A, fld(0, 0, 3'h4, 1, 8'h00), OK);
    rd_reg(REG_A, OK);
    chk(v, fld(0, 0, 3'h4, 1, thr[9]));
  endtask

  // Unmapped accesses and an out-of-range select have no effect
  task automatic t_refuse;
    wr_reg(BAD_A, fld(0, 1, 3'h0, 0, 8'hee), ERR);
    rd_reg(BAD_A, ERR);
    chk(v, 32'h0);
    wr_reg(REG_A, fld(0, 0, 3'h0, 0, 8'h00), OK);
    rd_reg(REG_A, OK);
    chk(v, fld(0, 0, 3'h0, 0, thr[0]));
    wr_reg(REG_A, fld(0, 1, 3'h5, 1, 8'h77), OK);
    rd_reg(REG_A, OK);
    chk(v, fld(0, 0, 3'h5, 1, 8'h00));
  endtask

  // Slow master: response and read data must stand until they are taken
  task automatic t_late_ready;
    lag = 4;
    wr_reg(REG_A, fld(0, 1, 3'h2, 1, 8'h3c), OK);
    rd_reg(REG_A, OK);
    chk(v, fld(0, 0, 3'h2, 1, 8'h3c));
    lag = 0;
  endtask

  // Main sequence: reset for ten cycles, then the scenarios
  initial begin
    arst_n = 1'b0; param_val = PV; fails = 0; checks_done = 0; lag = 0;
    awv = 1'b0; awa = 8'h00; wv = 1'b0; wd = 32'h0; ws = 4'h0; br = 1'b0;
    arv = 1'b0; ara = 8'h00; rr = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(REG_A, OK);
    chk(v, 32'h0);
    t_thr_table();
    t_sample();
    t_refuse();
    t_late_ready();
    finish_test();
  end
endmodule // tb
